// ===== hdl/bmx_uop_exec.v
// Execution unit for jump, branch, speculation-check, load and store micro-operations.
`include "bmx_defines.vh"
`default_nettype none

// Functional notes
// - Indirect jump sets user pointer to first operand.
// - Wrong predicted target: mispredict, annul, refetch.
// - Frontend places prediction in predicted-target immediate.
// - Bad user target page: fetch fault, no flags.
// - Microcode jumps redirect into internal space.
// - Microcode jumps freeze user pointer; decoder saves return.
// - Ordinary indirect jump resumes pointer updates.
// - Unconditional branch loads pointer with immediate.
// - Check compares operand to zero; eight conditions.
// - Check pass gives zero; fail raises, saves recovery.
// - Load address is sum; zero or sign extend.
// - Loads never merge subwords; decoder adds move.
// - Load merges cache data with inherited buffer.
// - Cache miss sets pending flag; no flags.
// - Condition field holds load alignment kind.
// - Low half rounds down; high half next chunk.
// - High half joins 128 bits, extracts, extends.
// - Access in low chunk: high half skips memory.
// - Ordinary misaligned load raises misalignment exception.
// - Absent or forbidden page raises read fault.
// - Store only builds forwarding entry; commit writes.
// - Store issues on address; replays for data.
module bmx_uop_exec #(
    parameter XW = 64
) (
    input  wire          mclk,
    input  wire          arst_n,
    input  wire          issue_valid,
    input  wire [3:0]    issue_op,
    input  wire [3:0]    issue_cond,
    input  wire [1:0]    issue_size,
    input  wire          issue_sign_ext,
    input  wire          issue_dest_is_ip,
    input  wire [XW-1:0] opnd_a,
    input  wire [XW-1:0] opnd_b,
    input  wire [XW-1:0] opnd_c,
    input  wire [XW-1:0] imm_target,
    input  wire [7:0]    imm_extype,
    input  wire          store_data_known,
    input  wire [XW-1:0] sfr_in_data,
    input  wire [7:0]    sfr_in_mask,
    input  wire          sfr_in_known,
    input  wire          tgt_page_present,
    input  wire          tgt_page_mapped,
    input  wire          tgt_page_noexec,
    input  wire          mem_page_present,
    input  wire          mem_page_allowed,
    input  wire          cache_hit,
    input  wire [XW-1:0] cache_rd_data,
    output wire          cache_rd_en,
    output wire [XW-1:0] cache_rd_addr,
    output reg           result_valid_reg,
    output reg  [XW-1:0] result_data_reg,
    output reg           result_pending_reg,
    output reg  [XW-1:0] user_ip_reg,
    output reg           ucode_mode_reg,
    output reg           redirect_valid_reg,
    output reg           redirect_internal_reg,
    output reg  [XW-1:0] redirect_addr_reg,
    output reg           annul_younger_reg,
    output reg           mispredict_exception_reg,
    output reg           fetch_page_fault_reg,
    output reg           read_page_fault_reg,
    output reg           misalignment_exception_reg,
    output reg           undefined_op_reg,
    output reg           check_fail_reg,
    output reg  [7:0]    check_extype_reg,
    output reg  [XW-1:0] recovery_ip_reg,
    output reg           sfr_out_valid_reg,
    output reg  [XW-1:0] sfr_out_addr_reg,
    output reg  [XW-1:0] sfr_out_data_reg,
    output reg  [7:0]    sfr_out_mask_reg,
    output reg           store_replay_reg
);

    // Byte-enable pattern for an access of 1, 2, 4 or 8 bytes.
    function [7:0] size_mask;
        input [1:0] sz;
        begin
            case (sz)
                2'h0:    size_mask = 8'h01;
                2'h1:    size_mask = 8'h03;
                2'h2:    size_mask = 8'h0f;
                default: size_mask = 8'hff;
            endcase
        end
    endfunction

    // Truncate to the access size, then zero or sign extend to 64 bits.
    function [63:0] extend;
        input [63:0] v;
        input [1:0]  sz;
        input        sx;
        begin
            case (sz)
                2'h0:    extend = {{56{sx & v[7]}}, v[7:0]};
                2'h1:    extend = {{48{sx & v[15]}}, v[15:0]};
                2'h2:    extend = {{32{sx & v[31]}}, v[31:0]};
                default: extend = v;
            endcase
        end
    endfunction

    reg rst_meta_reg;
    reg rst_sync_reg;
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    wire          is_jmp  = issue_valid && (issue_op == `BMX_OP_JMP);
    wire          is_jmpp = issue_valid && (issue_op == `BMX_OP_JMPP);
    wire          is_bru  = issue_valid && (issue_op == `BMX_OP_BRU);
    wire          is_brp  = issue_valid && (issue_op == `BMX_OP_BRP);
    wire          is_chk  = issue_valid && (issue_op == `BMX_OP_CHK);
    wire          is_ld   = issue_valid && (issue_op == `BMX_OP_LD);
    wire          is_st   = issue_valid && (issue_op == `BMX_OP_ST);
    wire          is_jump = is_jmp | is_jmpp | is_bru | is_brp;
    wire [XW-1:0] jump_tgt = (is_jmp | is_jmpp) ? opnd_a : imm_target;
    wire          jump_bad_dest = is_jump && !issue_dest_is_ip;
    // The internal space has no user page tables, so only user jumps are checked.
    wire          fetch_fault = (is_jmp | is_bru) && !jump_bad_dest &&
                                (!tgt_page_mapped || !tgt_page_present || tgt_page_noexec);
    // Prediction is taken to be the immediate; the frontend puts it there.
    wire          mispredict = (is_jmp | is_jmpp) && !jump_bad_dest && !fetch_fault &&
                               (opnd_a != imm_target);

    // Effective address and chunk selection.
    wire [XW-1:0] eff_addr = opnd_a + opnd_b;
    wire [2:0]    byte_off = eff_addr[2:0];
    wire [7:0]    acc_mask = size_mask(issue_size);
    wire          ld_norm = is_ld && (issue_cond == `BMX_ALIGN_NORM);
    wire          low_half_read_op   = is_ld && (issue_cond == `BMX_ALIGN_LO);
    wire          high_half_read_op   = is_ld && (issue_cond == `BMX_ALIGN_HI);
    wire          ld_bad_kind = is_ld && !ld_norm && !low_half_read_op && !high_half_read_op;
    wire [3:0]    acc_end = {1'b0, byte_off} + {1'b0, acc_mask[7], acc_mask[3],
                            acc_mask[1]} + 4'h1;
    wire          hi_skip = high_half_read_op && (acc_end <= `BMX_CHUNK_BYTES);
    wire [XW-1:0] chunk_addr = eff_addr & `BMX_CHUNK_MASK;
    // The offset bits below the access size must all be zero; the size minus one is the mask.
    wire          misaligned = ld_norm &&
                               ((byte_off & {acc_mask[7], acc_mask[3], acc_mask[1]}) != 3'h0);
    wire          ld_access = is_ld && !ld_bad_kind && !hi_skip && !misaligned;
    wire          read_fault = ld_access && (!mem_page_present || !mem_page_allowed);

    assign cache_rd_en   = ld_access && !read_fault;
    assign cache_rd_addr = high_half_read_op ? (chunk_addr + {60'h0, `BMX_CHUNK_BYTES}) : chunk_addr;

    // Forwarded bytes win over cache bytes, byte by byte.
    reg [63:0] merged;
    integer    i;
    always @*
    begin
        merged = 64'h0;
        for (i = 0; i < 8; i = i + 1)
            merged[i*8 +: 8] = sfr_in_mask[i] ? sfr_in_data[i*8 +: 8]
                                               : cache_rd_data[i*8 +: 8];
    end

    wire [63:0]  hi_part  = hi_skip ? 64'h0 : merged;
    wire [127:0] pair     = {hi_part, opnd_c} >> {byte_off, 3'h0};
    wire [63:0]  norm_val = merged >> {byte_off, 3'h0};
    // Results are always full width; merging into an old register is left to the decoder.
    wire [63:0]  ld_value = low_half_read_op ? merged :
                            high_half_read_op ? extend(pair[63:0], issue_size, issue_sign_ext) :
                                    extend(norm_val, issue_size, issue_sign_ext);

    // Speculation check on the numeric value only.
    reg chk_pass;
    reg chk_legal;
    always @*
    begin
        chk_legal = 1'b1;
        case (issue_cond)
            `BMX_CC_E:   chk_pass = (opnd_a == 64'h0);
            `BMX_CC_NE:  chk_pass = (opnd_a != 64'h0);
            `BMX_CC_BE:  chk_pass = (opnd_a == 64'h0);
            `BMX_CC_NBE: chk_pass = (opnd_a != 64'h0);
            `BMX_CC_L:   chk_pass = opnd_a[63];
            `BMX_CC_NL:  chk_pass = !opnd_a[63];
            `BMX_CC_LE:  chk_pass = opnd_a[63] || (opnd_a == 64'h0);
            `BMX_CC_NLE: chk_pass = !opnd_a[63] && (opnd_a != 64'h0);
            default:
            begin
                chk_pass  = 1'b0;
                chk_legal = 1'b0;
            end
        endcase
    end
    wire chk_fail = is_chk && chk_legal && !chk_pass;

    // Store data lands in the chosen bytes of the inherited forwarding entry.
    wire [7:0]  st_mask = acc_mask << byte_off;
    wire [63:0] st_data = opnd_c << {byte_off, 3'h0};
    reg  [63:0] st_merged;
    integer     j;
    always @*
    begin
        st_merged = 64'h0;
        for (j = 0; j < 8; j = j + 1)
            st_merged[j*8 +: 8] = st_mask[j] ? st_data[j*8 +: 8] : sfr_in_data[j*8 +: 8];
    end

    wire undefined = jump_bad_dest || ld_bad_kind || (is_chk && !chk_legal);
    wire jump_ok   = is_jump && !jump_bad_dest && !fetch_fault;

    always @(posedge mclk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            result_valid_reg           <= 1'b0;
            result_data_reg            <= 64'h0;
            result_pending_reg         <= 1'b0;
            user_ip_reg                <= `BMX_IP_RESET;
            ucode_mode_reg             <= 1'b0;
            redirect_valid_reg         <= 1'b0;
            redirect_internal_reg      <= 1'b0;
            redirect_addr_reg          <= 64'h0;
            annul_younger_reg          <= 1'b0;
            mispredict_exception_reg   <= 1'b0;
            fetch_page_fault_reg       <= 1'b0;
            read_page_fault_reg        <= 1'b0;
            misalignment_exception_reg <= 1'b0;
            undefined_op_reg           <= 1'b0;
            check_fail_reg             <= 1'b0;
            check_extype_reg           <= 8'h00;
            recovery_ip_reg            <= 64'h0;
            sfr_out_valid_reg          <= 1'b0;
            sfr_out_addr_reg           <= 64'h0;
            sfr_out_data_reg           <= 64'h0;
            sfr_out_mask_reg           <= 8'h00;
            store_replay_reg           <= 1'b0;
        end
        else
        begin
            result_valid_reg           <= (is_ld || is_chk) && !undefined;
            result_pending_reg         <= cache_rd_en && !cache_hit;
            mispredict_exception_reg   <= mispredict;
            // Annul and refetch leave on the same edge as the result, ahead of any younger commit.
            annul_younger_reg          <= mispredict;
            redirect_valid_reg         <= mispredict || (jump_ok && (is_bru || is_brp));
            redirect_internal_reg      <= is_jmpp || is_brp;
            redirect_addr_reg          <= jump_tgt;
            fetch_page_fault_reg       <= fetch_fault;
            read_page_fault_reg        <= read_fault;
            misalignment_exception_reg <= misaligned;
            undefined_op_reg           <= undefined;
            check_fail_reg             <= chk_fail;
            sfr_out_valid_reg          <= is_st;
            store_replay_reg           <= is_st && (!store_data_known || !sfr_in_known);
            if (is_ld)
                result_data_reg <= ld_value;
            else if (is_chk)
                result_data_reg <= chk_pass ? 64'h0 : imm_target;
            if (chk_fail)
            begin
                check_extype_reg <= imm_extype;
                recovery_ip_reg  <= imm_target;
            end
            if (jump_ok && is_jmp)
            begin
                user_ip_reg    <= opnd_a;
                ucode_mode_reg <= 1'b0;
            end
            else if (jump_ok && (is_jmpp || is_brp))
                ucode_mode_reg <= 1'b1;
            else if (jump_ok && is_bru && !ucode_mode_reg)
                user_ip_reg <= imm_target;
            if (is_st)
            begin
                sfr_out_addr_reg <= chunk_addr;
                sfr_out_data_reg <= st_merged;
                sfr_out_mask_reg <= st_mask | sfr_in_mask;
            end
        end
    end

endmodule

`default_nettype wire

// ===== hdl/bmx_defines.vh
// Shared encodings for the branch and memory operation execution block.
`ifndef BMX_DEFINES_VH
`define BMX_DEFINES_VH
`define BMX_OP_JMP       4'h0
`define BMX_OP_JMPP      4'h1
`define BMX_OP_BRU       4'h2
`define BMX_OP_BRP       4'h3
`define BMX_OP_CHK       4'h4
`define BMX_OP_LD        4'h5
`define BMX_OP_ST        4'h6
`define BMX_ALIGN_NORM   4'h0
`define BMX_ALIGN_LO     4'h1
`define BMX_ALIGN_HI     4'h2
`define BMX_CC_E         4'h4
`define BMX_CC_NE        4'h5
`define BMX_CC_BE        4'h6
`define BMX_CC_NBE       4'h7
`define BMX_CC_L         4'hc
`define BMX_CC_NL        4'hd
`define BMX_CC_LE        4'he
`define BMX_CC_NLE       4'hf
`define BMX_CHUNK_BYTES  4'h8
`define BMX_CHUNK_MASK   64'hffff_ffff_ffff_fff8
`define BMX_IP_RESET     64'h0
`endif

// ===== tb/bmx_uop_exec_monitor.sv
// Concurrent checks on the micro-operation execution block.
`include "bmx_defines.vh"
`default_nettype none
module bmx_uop_exec_monitor #(
    parameter XW = 64
) (
    input wire logic          mclk, arst_n, issue_valid, issue_dest_is_ip, store_data_known,
    input wire logic          sfr_in_known, tgt_page_present, tgt_page_mapped, tgt_page_noexec,
    input wire logic          mem_page_present, mem_page_allowed, cache_hit, cache_rd_en,
    input wire logic [3:0]    issue_op, issue_cond,
    input wire logic [1:0]    issue_size,
    input wire logic [XW-1:0] opnd_a, opnd_b, imm_target, cache_rd_addr, user_ip_reg,
    input wire logic [XW-1:0] redirect_addr_reg,
    input wire logic          result_valid_reg, result_pending_reg, ucode_mode_reg,
    input wire logic          redirect_valid_reg, redirect_internal_reg, annul_younger_reg,
    input wire logic          mispredict_exception_reg, fetch_page_fault_reg,
    input wire logic [7:0]    imm_extype, sfr_in_mask, check_extype_reg, sfr_out_mask_reg,
    input wire logic [XW-1:0] result_data_reg, recovery_ip_reg,
    input wire logic          check_fail_reg, undefined_op_reg, read_page_fault_reg,
    input wire logic          misalignment_exception_reg, sfr_out_valid_reg, store_replay_reg
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    wire [XW-1:0] ea = opnd_a + opnd_b;
    wire [2:0]    amask = (3'h1 << issue_size) - 3'h1;
    wire          jok = tgt_page_mapped && tgt_page_present && !tgt_page_noexec;
    wire          jmp = issue_valid && issue_op == `BMX_OP_JMP && issue_dest_is_ip;
    wire          ld = issue_valid && issue_op == `BMX_OP_LD;
    wire          ldn = ld && issue_cond == `BMX_ALIGN_NORM && (ea[2:0] & amask) == 3'h0;
    wire [7:0]    smask = 8'(((9'h1 << (4'h1 << issue_size)) - 9'h1) << ea[2:0]);
    sequence s_redir(logic [XW-1:0] t);
        redirect_valid_reg && redirect_addr_reg == t;
    endsequence
    AST_JMP_IP: assert property (jmp && jok |=> user_ip_reg == $past(opnd_a))
        else $error("jump left the user pointer wrong");
    AST_MISPREDICT: assert property (jmp && jok && opnd_a != imm_target |=>
        mispredict_exception_reg && annul_younger_reg ##0 s_redir($past(opnd_a)))
        else $error("mispredict not signalled");
    AST_FETCH_FAULT: assert property (jmp && !jok |=> fetch_page_fault_reg && $stable(user_ip_reg))
        else $error("fetch fault missing");
    AST_UCODE_BRANCH: assert property (issue_valid && issue_op == `BMX_OP_BRP && issue_dest_is_ip
        |=> s_redir($past(imm_target)) ##0 (redirect_internal_reg && ucode_mode_reg
        && $stable(user_ip_reg))) else $error("internal branch wrong");
    AST_BRU: assert property (issue_valid && issue_op == `BMX_OP_BRU && issue_dest_is_ip && jok
        && !ucode_mode_reg |=> s_redir($past(imm_target)) ##0 user_ip_reg == $past(imm_target))
        else $error("branch target wrong");
    AST_LO_ADDR: assert property (ld && issue_cond == `BMX_ALIGN_LO && cache_rd_en |->
        cache_rd_addr == (ea & `BMX_CHUNK_MASK)) else $error("low half address wrong");
    AST_MISALIGN: assert property (ld |=> misalignment_exception_reg ==
        $past(issue_cond == `BMX_ALIGN_NORM && (ea[2:0] & amask) != 3'h0))
        else $error("misalignment flag wrong");
    AST_MISS: assert property (ldn && mem_page_present && mem_page_allowed && !cache_hit
        |=> result_valid_reg && result_pending_reg) else $error("miss not pending");
    AST_STORE: assert property (issue_valid && issue_op == `BMX_OP_ST |=> sfr_out_valid_reg
        && store_replay_reg == $past(!(store_data_known && sfr_in_known)))
        else $error("store entry or replay wrong");
    AST_STORE_MASK: assert property (issue_valid && issue_op == `BMX_OP_ST |=>
        sfr_out_mask_reg == $past(smask | sfr_in_mask)) else $error("store mask wrong");
    AST_UNDEF: assert property (issue_valid && issue_op <= `BMX_OP_BRP && !issue_dest_is_ip
        |=> undefined_op_reg && !redirect_valid_reg) else $error("bad jump not undefined");
    AST_READ_FAULT: assert property (ldn && !(mem_page_present && mem_page_allowed)
        |=> read_page_fault_reg) else $error("read fault missing");
    AST_CHECK: assert property (issue_valid && issue_op == `BMX_OP_CHK |=>
        (check_fail_reg ? (recovery_ip_reg == $past(imm_target) && check_extype_reg ==
        $past(imm_extype) && result_data_reg == recovery_ip_reg) : result_data_reg == 64'h0))
        else $error("check result wrong");
endmodule
`default_nettype wire

// ===== tb/bmx_cache_model.sv
// Data cache stand-in that answers a read in the same cycle.
`default_nettype none
module bmx_cache_model (
    input  wire logic        rd_en,
    input  wire logic [63:0] rd_addr,
    input  wire logic        miss,
    output logic             hit,
    output logic [63:0]      data
);
    timeunit 1ns;
    timeprecision 1ns;
    // There is no write port: stores reach memory only when their entry commits.
    wire [63:0] word = {rd_addr[31:0] ^ 32'h5a3c_96e1, ~rd_addr[31:0]};
    assign hit = rd_en & ~miss;
    // Between reads the bus carries the inverse, so a stale sample cannot pass as an answer.
    assign data = rd_en ? word : ~word;
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the micro-operation execution block.
`include "bmx_defines.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, arst_n = 0, issue_valid = 0, issue_sign_ext = 0, miss = 0, v_d = 0, um = 0;
    logic issue_dest_is_ip = 1, store_data_known = 1, sfr_in_known = 1, mem_page_present = 1;
    logic tgt_page_present = 1, tgt_page_mapped = 1, tgt_page_noexec = 0, mem_page_allowed = 1;
    logic [3:0] issue_op = 0, issue_cond = 0;
    logic [1:0] issue_size = 0;
    logic [7:0] imm_extype = 0, sfr_in_mask = 0;
    logic [63:0] opnd_a = 0, opnd_b = 0, opnd_c = 0, imm_target = 0, sfr_in_data = 0, eip = 0;
    logic [128:0] n;
    logic [128:0] notes[$];
    logic [3:0] cc[8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'hd, 4'he, 4'hf};
    int mismatches = 0, n_tests = 0;
    wire cache_hit, cache_rd_en, result_valid_reg, result_pending_reg, ucode_mode_reg;
    wire redirect_valid_reg, redirect_internal_reg, annul_younger_reg, check_fail_reg;
    wire mispredict_exception_reg, fetch_page_fault_reg, read_page_fault_reg, undefined_op_reg;
    wire misalignment_exception_reg, sfr_out_valid_reg, store_replay_reg;
    wire [7:0] check_extype_reg, sfr_out_mask_reg;
    wire [63:0] cache_rd_data, cache_rd_addr, result_data_reg, user_ip_reg, redirect_addr_reg;
    wire [63:0] recovery_ip_reg, sfr_out_addr_reg, sfr_out_data_reg;
    bmx_uop_exec u_dut (.*);
    bmx_cache_model u_mem (.rd_en(cache_rd_en), .rd_addr(cache_rd_addr), .miss(miss),
                           .hit(cache_hit), .data(cache_rd_data));
    always #20 mclk = ~mclk;
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    function automatic logic [63:0] mrg(input logic [63:0] a);
        mrg = {a[31:0] ^ 32'h5a3c_96e1, ~a[31:0]};
        for (int i = 0; i < 8; i++)
            if (sfr_in_mask[i])
                mrg[8*i +: 8] = sfr_in_data[8*i +: 8];
    endfunction
    function automatic logic [63:0] ext(input logic [127:0] w, input logic [2:0] off);
        logic [63:0] v;
        logic [63:0] m;
        v = 64'(w >> (8 * off));
        m = ~64'h0 >> (64 - (8 << issue_size));
        ext = (issue_sign_ext && v[(8 << issue_size) - 1]) ? (v | ~m) : (v & m);
    endfunction
    function automatic logic pass(input logic [3:0] c, input logic [63:0] a);
        pass = c[0] ^ ((c[3:1] == 3'h6) ? a[63] : (a == 0) | (c[3:1] == 3'h7 && a[63]));
    endfunction
    // Operands stay up between back-to-back issues; the caller drops issue_valid at the end.
    task automatic go(input logic care, input logic [63:0] v);
        issue_valid = 1;
        notes.push_back({care, v, eip});
        @(posedge mclk);
        #1;
    endtask
    task automatic br(input logic [3:0] o, input logic [63:0] a, input logic [63:0] t,
                      input logic [2:0] pg, input logic ip);
        issue_op = o;
        opnd_a = a;
        imm_target = t;
        {tgt_page_mapped, tgt_page_present, tgt_page_noexec} = pg;
        issue_dest_is_ip = ip;
        if (ip && o == `BMX_OP_BRU && pg == 3'h6 && !um)
            eip = t;
        if (ip && o == `BMX_OP_JMP && pg == 3'h6)
            {um, eip} = {1'b0, a};
        if (ip && o[0])
            um = 1;
        go(0, 64'h0);
    endtask
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge mclk)
        v_d <= issue_valid;
    always @(negedge mclk)
        if (v_d && notes.size() > 0)
        begin
            n = notes.pop_front();
            check(user_ip_reg, n[63:0]);
            if (n[128])
                check(result_data_reg, n[127:64]);
        end
    initial
    begin
        logic [63:0] ea;
        ea = 64'($urandom(1));
        repeat (20) @(posedge mclk);
        #1;
        arst_n = 1;
        repeat (3) @(posedge mclk);
        #1;
        check(user_ip_reg, 64'h0);
        br(`BMX_OP_JMP, 64'h1000, 64'h1000, 3'h6, 1);
        br(`BMX_OP_JMP, 64'h2040, 64'h1000, 3'h6, 1);
        for (int i = 0; i < 3; i++)
            br(`BMX_OP_JMP, 64'h7000, 64'h7000, 3'h6 ^ (3'h1 << i), 1);
        br(`BMX_OP_JMP, 64'h7000, 64'h7000, 3'h6, 0);
        br(`BMX_OP_BRU, 64'h0, 64'h3000, 3'h6, 1);
        br(`BMX_OP_BRP, 64'h0, 64'h80, 3'h6, 1);
        br(`BMX_OP_BRU, 64'h0, 64'h5000, 3'h6, 1);
        br(`BMX_OP_JMPP, 64'h90, 64'h98, 3'h6, 1);
        br(`BMX_OP_JMP, 64'h3100, 64'h3100, 3'h6, 1);
        $display("jump tests done");
        issue_op = `BMX_OP_CHK;
        for (int i = 0; i < 24; i++)
        begin
            issue_cond = cc[i % 8];
            opnd_a = i < 8 ? 64'h0 : (i < 16 ? 64'h5 : ~64'h0);
            imm_target = {$urandom, $urandom};
            imm_extype = 8'($urandom);
            go(1, pass(issue_cond, opnd_a) ? 64'h0 : imm_target);
        end
        $display("check tests done");
        issue_op = `BMX_OP_LD;
        for (int i = 0; i < 90; i++)
        begin
            issue_cond = 4'($urandom % 3);
            {issue_size, issue_sign_ext, sfr_in_mask} = 11'($urandom);
            {opnd_a, opnd_b, opnd_c} = {$urandom, $urandom, 60'h0, 4'($urandom), $urandom, $urandom};
            sfr_in_data = {$urandom, $urandom};
            {mem_page_present, mem_page_allowed} = ($urandom % 8) != 0 ? 2'h3 : 2'($urandom);
            miss = ($urandom % 6) == 0;
            ea = opnd_a + opnd_b;
            if (issue_cond == `BMX_ALIGN_HI)
                go((ea[2:0] + (4'h1 << issue_size) <= 4'h8) || (&{mem_page_present,
                   mem_page_allowed, !miss}), ext({mrg((ea & `BMX_CHUNK_MASK) + 64'h8), opnd_c},
                   ea[2:0]));
            else if (issue_cond == `BMX_ALIGN_LO)
                go(&{mem_page_present, mem_page_allowed, !miss}, mrg(ea & `BMX_CHUNK_MASK));
            else
                go(&{mem_page_present, mem_page_allowed, !miss, issue_cond == 0, (ea[2:0] &
                   ((3'h1 << issue_size) - 3'h1)) == 0}, ext({64'h0, mrg(ea & `BMX_CHUNK_MASK)},
                   ea[2:0]));
        end
        miss = 0;
        issue_op = `BMX_OP_ST;
        for (int i = 0; i < 4; i++)
        begin
            {store_data_known, sfr_in_known} = 2'(i);
            go(0, 64'h0);
        end
        issue_valid = 0;
        $display("memory tests done");
        repeat (3) @(posedge mclk);
        complete_run;
    end
endmodule
bind bmx_uop_exec bmx_uop_exec_monitor #(.XW(XW)) u_mon (.*);
`default_nettype wire
